// file: hdl/slwd_top.sv
// receive-link control registers and link watchdog behind an AHB-Lite slave
// assumes: link status inputs come from logic on hclk; one master, word transfers
// Behaviour
// [R1] rate code scales PLL to line rate
// [R2] software changes settings only with link disabled
// [R3] software sets low VCO band below 2.17GHz
// [R4] manual sync bit low asserts SYNC
// [R5] no manual sync while encoding select set
// [R6] five-bit code selects PRBS test mode
// [R7] expiry resets PLL too when enabled
// [R8] healthy link decrements counter by selected step
// [R9] three-bit code selects watchdog threshold
// [R10] threshold reached resets PHY and counter
// [R11] link status sampled every 1024 cycles
// [R12] unhealthy interval increments, decrement saturates zero
// [R13] link up once elastic buffer released
// [R14] CRC alarm over threshold, cleared by run
`include "slwd_map.svh"
module slwd_top #(
   parameter int LANES = 16,
   parameter int WD_TH1_LOG2 = 17,
   parameter int WD_TH2_LOG2 = 19,
   parameter int WD_TH3_LOG2 = 21,
   parameter int WD_TH4_LOG2 = 23,
   parameter int CRC_ERR_TH_MB = 1,
   parameter int CRC_ERR_REC_MB = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic eb_released,
   input wire logic [LANES-1:0] mb_strobe,
   input wire logic [LANES-1:0] mb_crc_err,
   output slwd_pkg::slwd_phy_ctl_t phy_ctl,
   output slwd_pkg::slwd_phy_rst_t phy_rst,
   output logic link_sync_n,
   output logic link_enable,
   output logic link_encoding_select,
   output logic [2:0] sync_error_pulse_width
);
   import slwd_pkg::*;

   localparam int WDW = 14;
   localparam logic [WDW-1:0] TH1 = WDW'(1 << (WD_TH1_LOG2 - `SLWD_SAMPLE_LOG2));
   localparam logic [WDW-1:0] TH2 = WDW'(1 << (WD_TH2_LOG2 - `SLWD_SAMPLE_LOG2));
   localparam logic [WDW-1:0] TH3 = WDW'(1 << (WD_TH3_LOG2 - `SLWD_SAMPLE_LOG2));
   localparam logic [WDW-1:0] TH4 = WDW'(1 << (WD_TH4_LOG2 - `SLWD_SAMPLE_LOG2));
   localparam logic [9:0] SMP_LAST = 10'(`SLWD_SAMPLE_CYCLES - 1);
   localparam logic [3:0] CRC_TH = 4'(CRC_ERR_TH_MB);
   localparam logic [6:0] CRC_REC = 7'(CRC_ERR_REC_MB);

   // the counter works in sampling intervals, so thresholds are cycles / 1024
   function automatic logic [WDW-1:0] th_lim(input logic [2:0] s);
      case (s)
         3'h1: th_lim = TH1;
         3'h2: th_lim = TH2;
         3'h3: th_lim = TH3;
         3'h4: th_lim = TH4;
         default: th_lim = '0;
      endcase
   endfunction

   function automatic logic [WDW-1:0] dec_step(input logic [1:0] s);
      case (s)
         2'h0: dec_step = 14'h0001;
         2'h1: dec_step = 14'h0002;
         2'h2: dec_step = 14'h0008;
         default: dec_step = 14'h0010;
      endcase
   endfunction

   function automatic logic [3:0] mult_x2(input slwd_rate_t r);
      case (r)
         SLWD_RATE_X4: mult_x2 = 4'h8;
         SLWD_RATE_X2: mult_x2 = 4'h4;
         SLWD_RATE_X1: mult_x2 = 4'h2;
         default: mult_x2 = 4'h1;
      endcase
   endfunction

   // register file
   logic [1:0] rate_q;
   logic vco_q;
   logic sync_q;
   logic [4:0] prbs_q;
   slwd_wdctl_t wdctl_q;
   logic [2:0] epw_q;
   logic en_q;
   logic enc_q;
   logic ber_q;

   // bus
   logic wr_pend_q;
   logic [11:0] wa_q;
   logic [31:0] rdata_q;
   logic hready_q;
   logic hresp_q;

   // watchdog
   slwd_wd_state_t st_q;
   slwd_wd_state_t st_d;
   logic [WDW-1:0] cnt_q;
   logic [WDW-1:0] cnt_d;
   logic [9:0] smp_q;
   logic link_up_q;
   logic crc_alarm_q;
   slwd_phy_ctl_t phy_ctl_q;
   slwd_phy_rst_t phy_rst_q;
   logic sync_out_q;

   // per-lane crc supervision
   logic [3:0] err_q [LANES];
   logic [6:0] ok_q [LANES];
   logic [LANES-1:0] lane_alarm_q;

   wire acc = hsel & htrans[1] & hready;
   wire [11:0] aidx = haddr[13:2];
   wire amap = (haddr[31:14] == 18'h00000);
   wire wr_take = acc & hwrite & (hsize == 3'b010);
   wire rd_take = acc & ~hwrite;
   wire wr_go = wr_pend_q;
   wire [31:0] stat_word = {2'b00, cnt_q, 12'h000, st_q, crc_alarm_q, link_up_q};

   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      if (amap) begin
         case (aidx)
            `SLWD_IDX_CTRL: rd_word = {29'h0, ber_q, enc_q, en_q};
            `SLWD_IDX_STAT: rd_word = stat_word;
            `SLWD_IDX_RATE: rd_word = {30'h0, rate_q};
            `SLWD_IDX_VCO: rd_word = {31'h0, vco_q};
            `SLWD_IDX_SYNC: rd_word = {31'h0, sync_q};
            `SLWD_IDX_PRBS: rd_word = {27'h0, prbs_q};
            `SLWD_IDX_WDOG: rd_word = {24'h0, wdctl_q.pll_rst_en, 1'b0, wdctl_q.dec_sel, 1'b0, wdctl_q.th_sel};
            `SLWD_IDX_EPW: rd_word = {29'h0, epw_q};
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wa_q <= 12'h000;
         rdata_q <= 32'h0000_0000;
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         // zero wait states and always OKAY, still taken from flops like every other output
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
         wr_pend_q <= wr_take & amap;
         wa_q <= aidx;
         rdata_q <= rd_take ? rd_word : 32'h0000_0000;
      end
   end

   // writes land in the data phase; unmapped indices are simply ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_q <= 2'b00;
         vco_q <= 1'b0; // [R3]
         sync_q <= 1'b1; // [R4]
         prbs_q <= 5'h00;
         wdctl_q <= 6'h00;
         epw_q <= 3'h0;
         en_q <= 1'b0;
         enc_q <= 1'b0;
         ber_q <= 1'b0;
      end else if (wr_go) begin
         case (wa_q)
            `SLWD_IDX_CTRL: begin
               en_q <= hwdata[`SLWD_CTRL_EN_BIT];
               enc_q <= hwdata[`SLWD_CTRL_ENC_BIT];
               ber_q <= hwdata[`SLWD_CTRL_BER_BIT];
            end
            `SLWD_IDX_RATE: rate_q <= hwdata[1:0]; // [R1]
            `SLWD_IDX_VCO: vco_q <= hwdata[0];
            `SLWD_IDX_SYNC: sync_q <= hwdata[0];
            `SLWD_IDX_PRBS: prbs_q <= hwdata[4:0];
            `SLWD_IDX_WDOG: begin
               wdctl_q.pll_rst_en <= hwdata[`SLWD_WD_PLL_BIT];
               wdctl_q.dec_sel <= hwdata[`SLWD_WD_DEC_LSB +: 2];
               wdctl_q.th_sel <= hwdata[`SLWD_WD_TH_LSB +: 3];
            end
            `SLWD_IDX_EPW: epw_q <= hwdata[2:0];
            default: en_q <= en_q;
         endcase
      end
   end

   // settings are not shadowed: software keeps them still while the link is enabled [R2]
   wire prbs_ok = (prbs_q <= `SLWD_PRBS_MAX);
   wire [WDW-1:0] lim = th_lim(wdctl_q.th_sel);
   wire [WDW-1:0] step = dec_step(wdctl_q.dec_sel);
   wire wd_on = en_q & (lim != '0); // [R9]
   wire smp_last = (smp_q == SMP_LAST); // [R11]
   wire healthy = link_up_q & ~crc_alarm_q;
   wire wd_hit = (cnt_q >= lim); // [R10]
   wire [WDW-1:0] cnt_dec = (cnt_q > step) ? cnt_q - step : '0; // [R12]
   wire [WDW-1:0] cnt_inc = cnt_q + 14'h0001;
   wire go_exp = (st_q == SLWD_WD_RUN) & wd_on & wd_hit;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         SLWD_WD_OFF: begin
            cnt_d = '0;
            if (wd_on) begin
               st_d = SLWD_WD_RUN;
            end
         end
         SLWD_WD_RUN: begin
            if (!wd_on) begin
               st_d = SLWD_WD_OFF;
               cnt_d = '0;
            end else if (wd_hit) begin
               st_d = SLWD_WD_EXPIRE;
               cnt_d = '0; // [R10]
            end else if (smp_last) begin
               cnt_d = healthy ? cnt_dec : cnt_inc; // [R8] [R12]
            end
         end
         SLWD_WD_EXPIRE: begin
            st_d = wd_on ? SLWD_WD_RUN : SLWD_WD_OFF;
            cnt_d = '0;
         end
         default: begin
            st_d = SLWD_WD_OFF;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= SLWD_WD_OFF;
         cnt_q <= '0;
         smp_q <= 10'h000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         smp_q <= (st_d == SLWD_WD_RUN) ? smp_q + 10'h001 : 10'h000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phy_rst_q <= 2'b00;
         link_up_q <= 1'b0;
         sync_out_q <= 1'b1;
         phy_ctl_q <= '0;
      end else begin
         phy_rst_q.rx_reset <= go_exp; // [R10]
         phy_rst_q.pll_reset <= go_exp & wdctl_q.pll_rst_en; // [R7]
         link_up_q <= eb_released; // [R13]
         // encoding select high with a forced sync is left to software to avoid [R5]
         sync_out_q <= sync_q; // [R4]
         phy_ctl_q.rate <= slwd_rate_t'(rate_q); // [R1]
         phy_ctl_q.line_mult_x2 <= mult_x2(slwd_rate_t'(rate_q)); // [R1]
         phy_ctl_q.vco_low_band_select <= vco_q;
         // reserved test codes fall back to normal traffic rather than an unknown pattern
         phy_ctl_q.prbs_test_select <= prbs_ok ? slwd_prbs_t'(prbs_q) : SLWD_PRBS_OFF; // [R6]
         phy_ctl_q.bit_error_count_enable <= ber_q;
      end
   end

   // an errored block restarts the clean run; a clean run long enough clears that lane's count and alarm [R14]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < LANES; i++) begin
            err_q[i] <= 4'h0;
            ok_q[i] <= 7'h00;
         end
         lane_alarm_q <= '0;
         crc_alarm_q <= 1'b0;
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (mb_strobe[i] && mb_crc_err[i]) begin
               ok_q[i] <= 7'h00;
               err_q[i] <= (err_q[i] == 4'hf) ? 4'hf : err_q[i] + 4'h1;
               if (err_q[i] + 4'h1 >= CRC_TH) begin
                  lane_alarm_q[i] <= 1'b1; // [R14]
               end
            end else if (mb_strobe[i]) begin
               if (ok_q[i] + 7'h01 >= CRC_REC) begin
                  ok_q[i] <= 7'h00;
                  err_q[i] <= 4'h0;
                  lane_alarm_q[i] <= 1'b0; // [R14]
               end else begin
                  ok_q[i] <= ok_q[i] + 7'h01;
               end
            end
         end
         crc_alarm_q <= |lane_alarm_q;
      end
   end

   assign hreadyout = hready_q;
   assign hresp = hresp_q;
   assign hrdata = rdata_q;
   assign phy_ctl = phy_ctl_q;
   assign phy_rst = phy_rst_q;
   assign link_sync_n = sync_out_q;
   assign link_enable = en_q;
   assign link_encoding_select = enc_q;
   assign sync_error_pulse_width = epw_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_RATE_WRITE: assert property (wr_go && wa_q == `SLWD_IDX_RATE // [R1]
      |-> ##2 phy_ctl.line_mult_x2 == mult_x2(slwd_rate_t'($past(hwdata[1:0], 2))))
      else $error("line multiplier does not follow rate write");
   AST_SYNC_FORCE: assert property (wr_go && wa_q == `SLWD_IDX_SYNC && !hwdata[0] // [R4]
      |-> ##2 !link_sync_n)
      else $error("sync not asserted after manual level 0");
   AST_PRBS_RSVD: assert property (prbs_q > `SLWD_PRBS_MAX // [R6]
      |=> phy_ctl.prbs_test_select == SLWD_PRBS_OFF)
      else $error("reserved test code not mapped to normal");
   AST_PLL_GATE: assert property (phy_rst.pll_reset // [R7]
      |-> phy_rst.rx_reset && $past(wdctl_q.pll_rst_en))
      else $error("pll reset without receiver reset or enable");
   AST_DEC16: assert property (st_q == SLWD_WD_RUN && wd_on && !wd_hit && smp_last // [R8]
      && healthy && wdctl_q.dec_sel == 2'h3
      |=> cnt_q == (($past(cnt_q) >= 14'h0010) ? $past(cnt_q) - 14'h0010 : 14'h0000))
      else $error("decrement step of 16 not applied");
   AST_TH_OFF: assert property (wdctl_q.th_sel == 3'h0 || !en_q // [R9]
      |=> !phy_rst.rx_reset)
      else $error("watchdog fired while disabled");
   AST_EXPIRE_CLR: assert property (phy_rst.rx_reset // [R10]
      |-> cnt_q == '0 ##1 !phy_rst.rx_reset)
      else $error("expiry did not clear counter or reset held");
   AST_SAMPLE_ONLY: assert property (st_q == SLWD_WD_RUN && $past(st_q) == SLWD_WD_RUN // [R11]
      && $changed(cnt_q) && cnt_q != '0 |-> $past(smp_q) == SMP_LAST)
      else $error("counter moved between samples");
   AST_INC_UNHEALTHY: assert property (st_q == SLWD_WD_RUN && wd_on && !wd_hit // [R12]
      && smp_last && !healthy |=> cnt_q == $past(cnt_q) + 14'h0001)
      else $error("unhealthy interval did not increment");
   AST_LINK_UP: assert property (eb_released ##1 eb_released // [R13]
      |-> link_up_q && stat_word[`SLWD_STAT_UP_BIT])
      else $error("link up not reported");

   COV_EXPIRE_PLL: cover property (phy_rst.rx_reset && phy_rst.pll_reset);
   COV_PRBS31: cover property (phy_ctl.prbs_test_select == SLWD_PRBS_31);
   COV_CRC_ALARM: cover property ($rose(crc_alarm_q));
   COV_SATURATE: cover property (smp_last && healthy && cnt_q != '0 ##1 cnt_q == '0);
endmodule

// file: hdl/slwd_map.svh
// register indices, field positions, reset values and counts of the link watchdog
// assumes: included by the top module and the bench, byte address = 4 * index
`ifndef SLWD_MAP_SVH
`define SLWD_MAP_SVH
`define SLWD_IDX_CTRL 12'h100
`define SLWD_IDX_STAT 12'h101
`define SLWD_IDX_RATE 12'h10a
`define SLWD_IDX_VCO 12'h10b
`define SLWD_IDX_SYNC 12'h120
`define SLWD_IDX_PRBS 12'h121
`define SLWD_IDX_WDOG 12'h124
`define SLWD_IDX_EPW 12'h127
`define SLWD_RST_ZERO 8'h00
`define SLWD_RST_SYNC 8'h01
`define SLWD_CTRL_EN_BIT 0
`define SLWD_CTRL_ENC_BIT 1
`define SLWD_CTRL_BER_BIT 2
`define SLWD_STAT_UP_BIT 0
`define SLWD_STAT_CRC_BIT 1
`define SLWD_STAT_ST_LSB 2
`define SLWD_STAT_CNT_LSB 16
`define SLWD_WD_PLL_BIT 7
`define SLWD_WD_DEC_LSB 4
`define SLWD_WD_TH_LSB 0
`define SLWD_PRBS_MAX 5'h04
`define SLWD_SAMPLE_CYCLES 1024
`define SLWD_SAMPLE_LOG2 10
`endif

// file: hdl/slwd_pkg.sv
// types shared by the link watchdog block and its bench
// assumes: the map header sits on the include path
package slwd_pkg;
   typedef enum logic [1:0] {
      SLWD_RATE_X4 = 2'b00,
      SLWD_RATE_X2 = 2'b01,
      SLWD_RATE_X1 = 2'b10,
      SLWD_RATE_XHALF = 2'b11
   } slwd_rate_t;
   typedef enum logic [4:0] {
      SLWD_PRBS_OFF = 5'b00000,
      SLWD_PRBS_7 = 5'b00001,
      SLWD_PRBS_9 = 5'b00010,
      SLWD_PRBS_15 = 5'b00011,
      SLWD_PRBS_31 = 5'b00100
   } slwd_prbs_t;
   typedef enum logic [1:0] {
      SLWD_WD_OFF = 2'b00,
      SLWD_WD_RUN = 2'b01,
      SLWD_WD_EXPIRE = 2'b10
   } slwd_wd_state_t;
   typedef struct packed {
      logic pll_rst_en;
      logic [1:0] dec_sel;
      logic [2:0] th_sel;
   } slwd_wdctl_t;
   typedef struct packed {
      slwd_rate_t rate;
      logic [3:0] line_mult_x2;
      logic vco_low_band_select;
      slwd_prbs_t prbs_test_select;
      logic bit_error_count_enable;
   } slwd_phy_ctl_t;
   typedef struct packed {
      logic rx_reset;
      logic pll_reset;
   } slwd_phy_rst_t;
endpackage

// file: test/slwd_link_tx.sv
// far-end transmitter model: releases the buffer and sends multiblocks
// assumes: driven from the bench on hclk; lane 0 carries the error flag
module slwd_link_tx #(
   parameter int LANES = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic up,
   input wire logic err_req,
   output logic eb_released,
   output logic [LANES-1:0] mb_strobe,
   output logic [LANES-1:0] mb_crc_err
);
   logic [2:0] div_q;
   logic blk;
   assign blk = up && (div_q == 3'h7);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 3'h0;
         eb_released <= 1'b0;
         mb_strobe <= '0;
         mb_crc_err <= '0;
      end else begin
         div_q <= div_q + 3'h1;
         eb_released <= up;
         mb_strobe <= blk ? '1 : '0;
         // error flags are only valid with a strobe, so they toggle between blocks
         mb_crc_err <= blk ? {{(LANES-1){1'b0}}, err_req} : ~mb_crc_err;
      end
   end
endmodule

// file: test/tb.sv
// self-checking bench for the link watchdog block
// assumes: slwd_top, slwd_link_tx and the map header on the include path
`include "slwd_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import slwd_pkg::*;
   logic hclk, hresetn, hsel, hwrite, up, err_req, hreadyout, hresp;
   logic eb_released, link_sync_n, en, enc;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, epw;
   logic [15:0] mb_strobe, mb_crc_err;
   slwd_phy_ctl_t phy_ctl;
   slwd_phy_rst_t phy_rst;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int w;
   // short thresholds: 2, 4, 8, 16 sampling intervals
   slwd_top #(.WD_TH1_LOG2(11), .WD_TH2_LOG2(12), .WD_TH3_LOG2(13), .WD_TH4_LOG2(14)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .eb_released(eb_released),
      .mb_strobe(mb_strobe), .mb_crc_err(mb_crc_err), .phy_ctl(phy_ctl), .phy_rst(phy_rst),
      .link_sync_n(link_sync_n), .link_enable(en), .link_encoding_select(enc),
      .sync_error_pulse_width(epw));
   slwd_link_tx #(.LANES(16)) u_tx (.hclk(hclk), .hresetn(hresetn), .up(up), .err_req(err_req),
      .eb_released(eb_released), .mb_strobe(mb_strobe), .mb_crc_err(mb_crc_err));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic ready();
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
   endtask
   // one single word transfer; the master waits for hready in both phases
   task automatic bus(logic wr, logic [11:0] idx, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      haddr <= {18'h0, idx, 2'b00};
      ready();
      htrans <= 2'b00;
      hwdata <= d;
      ready();
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic wr(logic [11:0] idx, logic [31:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rdchk(string what, logic [11:0] idx, logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic settle();
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task automatic t_reset();
      chk("sync out", 32'h1, link_sync_n);
      chk("hready", 32'h1, hreadyout);
      chk("hresp", 32'h0, hresp);
      rdchk("ctrl", `SLWD_IDX_CTRL, 32'h0);
      rdchk("rate", `SLWD_IDX_RATE, 32'h0);
      rdchk("vco", `SLWD_IDX_VCO, 32'h0);
      rdchk("sync", `SLWD_IDX_SYNC, 32'h1);
      rdchk("prbs", `SLWD_IDX_PRBS, 32'h0);
      rdchk("wdog", `SLWD_IDX_WDOG, 32'h0);
      rdchk("epw", `SLWD_IDX_EPW, 32'h0);
   endtask
   task automatic t_ctl();
      for (int c = 0; c < 4; c++) begin
         wr(`SLWD_IDX_RATE, 32'(c));
         settle();
         chk("rate out", 32'(c), phy_ctl.rate);
         chk("mult", 32'(8 >> c), phy_ctl.line_mult_x2);
      end
      for (int c = 0; c < 6; c++) begin
         wr(`SLWD_IDX_PRBS, 32'(c));
         settle();
         chk("prbs out", (c < 5) ? 32'(c) : 32'h0, phy_ctl.prbs_test_select);
         rdchk("prbs back", `SLWD_IDX_PRBS, 32'(c));
      end
      wr(`SLWD_IDX_VCO, 32'h1);
      settle();
      chk("vco out", 32'h1, phy_ctl.vco_low_band_select);
      wr(`SLWD_IDX_EPW, 32'h5);
      settle();
      chk("epw out", 32'h5, epw);
      wr(`SLWD_IDX_CTRL, 32'h7);
      settle();
      chk("link enable", 32'h1, en);
      chk("encoding", 32'h1, enc);
      chk("ber out", 32'h1, phy_ctl.bit_error_count_enable);
      rdchk("ctrl", `SLWD_IDX_CTRL, 32'h7);
      wr(`SLWD_IDX_CTRL, 32'h0);
      wr(12'h200, 32'hff);
      rdchk("unmapped", 12'h200, 32'h0);
   endtask
   task automatic t_sync();
      // encoding select stays 0 here, so a forced sync is defined
      wr(`SLWD_IDX_SYNC, 32'h0);
      settle();
      chk("sync forced", 32'h0, link_sync_n);
      wr(`SLWD_IDX_SYNC, 32'h1);
      settle();
      chk("sync normal", 32'h1, link_sync_n);
   endtask
   // settings change only with the link disabled
   task automatic arm(logic [31:0] cfg);
      wr(`SLWD_IDX_CTRL, 32'h0);
      wr(`SLWD_IDX_WDOG, cfg);
      wr(`SLWD_IDX_CTRL, 32'h1);
   endtask
   task automatic t_expire(logic pll);
      up <= 1'b0;
      arm({24'h0, pll, 7'h01});
      w = 0;
      while (phy_rst.rx_reset !== 1'b1 && w < 2400) begin
         @(posedge hclk);
         w++;
      end
      chk("expiry late", 32'h1, w > 2040 && w < 2400);
      chk("pll reset", 32'(pll), phy_rst.pll_reset);
      @(posedge hclk);
      chk("rx reset pulse", 32'h0, phy_rst.rx_reset);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("count cleared", 32'h0, rd[29:16]);
   endtask
   task automatic t_off();
      arm(32'h0);
      w = 0;
      repeat (3000) begin
         @(posedge hclk);
         if (phy_rst.rx_reset !== 1'b0) w++;
      end
      chk("disabled resets", 32'h0, w);
   endtask
   task automatic t_count();
      up <= 1'b0;
      arm(32'h12);
      repeat (3 * 1024 + 400) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("count up", 32'h3, rd[29:16]);
      chk("state run", 32'h1, rd[3:2]);
      chk("link down", 32'h0, rd[0]);
      up <= 1'b1;
      repeat (1024) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("count step 2", 32'h1, rd[29:16]);
      repeat (1024) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("count floor", 32'h0, rd[29:16]);
      chk("link up", 32'h1, rd[0]);
      err_req <= 1'b1;
      repeat (40) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("crc alarm", 32'h1, rd[1]);
      err_req <= 1'b0;
      repeat (40) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("crc clear", 32'h0, rd[1]);
      wr(`SLWD_IDX_CTRL, 32'h0);
   endtask
   // a count of 3 with step 16 must land on zero, where step 2 would leave 1
   task automatic t_dec16();
      up <= 1'b0;
      arm(32'h32);
      repeat (3 * 1024 + 400) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("count before", 32'h3, rd[29:16]);
      up <= 1'b1;
      repeat (1024) @(posedge hclk);
      bus(1'b0, `SLWD_IDX_STAT, 32'h0);
      chk("count step 16", 32'h0, rd[29:16]);
      wr(`SLWD_IDX_CTRL, 32'h0);
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      forever begin
         @(posedge hclk);
         cyc++;
         if (cyc == 40000) begin
            fail_count++;
            stop_test();
         end
      end
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      up = 1'b0;
      err_req = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_ctl();
      t_sync();
      t_expire(1'b1);
      t_expire(1'b0);
      t_off();
      t_count();
      t_dec16();
      stop_test();
   end
endmodule
